/* verilog/cs_selector.sv */
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Operation
// R1: bit7 high while adapter feeds system, gate drive
// R2: adapter path needs adapter present, learn clear
// R3: learn cycle, depleted battery: switch to adapter
// R4: adapter overcurrent cuts adapter path immediately
// R5: bit8 high while over-temperature holds charger off
// R6: above 145 C disable charging, raise alarm
// R7: register access keeps working during thermal shutdown
// R8: stay off until below 130 C, then restart
// R9: bit9 high while thermistor above cold level
// R10: bit10 high while thermistor below hot level
// R11: hot level chosen by charging active or not
// R12: five volt reference on only with adapter
// R13: host selects learn cycle with control bit4
// R14: status reads live, reads have no side effect
module cs_selector (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator pins, asynchronous
    input  wire logic        adapter_detect_input,
    input  wire logic        adapter_overcurrent_event,
    input  wire logic        battery_depleted_threshold,
    input  wire logic        therm_above_cold,
    input  wire logic        therm_below_hot_start,
    input  wire logic        therm_below_hot_oper,
    // die temperature sensor, same clock, degrees celsius
    input  wire logic [7:0]  die_temp_c,
    // power path and charger controls
    output logic             adapter_switch_gate_drive,
    output logic             charger_enable,
    output logic             five_volt_reference,
    output logic             alarm,
    output logic             irq
);

    typedef struct packed {
        logic [31:0]         prdata;    // read data, loaded in setup
        logic                pready;    // answer in access phase
        logic                pslverr;   // unmapped address
        logic                chg_en;    // host charge enable
        logic                learn;     // learn cycle selected
        logic [4:0]          int_stat;  // sticky events
        logic [4:0]          int_mask;  // event enables
        logic                oc_trip;   // overcurrent latch
        logic                learn_sw;  // learn switchover latched
        logic                tshut;     // thermal shutdown
        logic                gate;      // adapter path on
        logic                chg_on;    // charger running
        logic                ref_en;    // 5 v reference enable
        logic                alarm;     // alarm toward host
        logic                irq;       // interrupt level
        logic [4:0]          prev_ev;   // event conditions, last cycle
    } cs_state_t;

    cs_state_t cur;       // registered state
    cs_state_t next_cur;  // next state

    logic [cs_pkg::CS_IN_N-1:0] pin_raw;  // pins before crossing
    logic [cs_pkg::CS_IN_N-1:0] pin;      // pins after crossing

    assign pin_raw = {therm_below_hot_oper, therm_below_hot_start,
                      therm_above_cold, battery_depleted_threshold,
                      adapter_overcurrent_event, adapter_detect_input};

    // every comparator pin is asynchronous to clk
    cs_sync #(
        .W (cs_pkg::CS_IN_N)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (pin_raw),
        .q     (pin)
    );

    // derived conditions
    logic        ac_present;   // adapter detected
    logic        overcur;      // adapter overcurrent now
    logic        depleted;     // battery below depleted level
    logic        therm_cold;   // live cold flag
    logic        therm_hot;    // live hot flag
    logic        ac_want;      // adapter path request
    logic [4:0]  ev_now;       // event conditions
    logic [4:0]  ev_rise;      // new events this cycle
    logic [4:0]  w1c;          // bits cleared by software
    logic [31:0] status_word;  // live status read value
    logic        wr_acc;       // write takes effect
    logic        rd_set;       // read setup phase

    always_comb begin
        ac_present = pin[cs_pkg::CS_IN_ADAPTER];
        overcur    = pin[cs_pkg::CS_IN_OVERCUR];
        depleted   = pin[cs_pkg::CS_IN_DEPLETED];
        therm_cold = pin[cs_pkg::CS_IN_COLD];  // R9
        // operating level while charging, start level otherwise
        therm_hot  = cur.chg_on ? pin[cs_pkg::CS_IN_HOT_OP]
                                : pin[cs_pkg::CS_IN_HOT_ST];  // R10 R11
        // learn clear, or learn with switchover already taken
        ac_want    = ac_present && (!cur.learn || cur.learn_sw);  // R2 R3
        // status word built from live state, no latching
        status_word = 32'h0000_0000;
        status_word[cs_pkg::CS_ST_ADAPTER_PATH] = cur.gate;  // R1 R14
        status_word[cs_pkg::CS_ST_THERMAL_OFF]  = cur.tshut;  // R5
        status_word[cs_pkg::CS_ST_COLD]         = therm_cold;  // R9
        status_word[cs_pkg::CS_ST_HOT]          = therm_hot;  // R10
        wr_acc = psel && penable && cur.pready && pwrite;
        rd_set = psel && !penable && !pwrite;
        ev_now = '0;
        ev_now[cs_pkg::CS_EV_THERMAL]  = cur.tshut;
        ev_now[cs_pkg::CS_EV_OVERCUR]  = cur.oc_trip;
        ev_now[cs_pkg::CS_EV_LEARN_SW] = cur.learn_sw;
        ev_now[cs_pkg::CS_EV_COLD]     = therm_cold;
        ev_now[cs_pkg::CS_EV_HOT]      = therm_hot;
        ev_rise = ev_now & ~cur.prev_ev;
        w1c = '0;
        if (wr_acc && paddr == cs_pkg::CS_INT_STAT_OFS) begin
            w1c = pwdata[4:0];
        end
    end

    // next-state logic for the whole block
    always_comb begin
        next_cur = cur;
        next_cur.prev_ev = ev_now;

        // apb: decode in setup, answer in the first access cycle;
        // register path never depends on charger state
        next_cur.pready  = psel && !penable && !cur.pready;  // R7
        next_cur.pslverr = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                cs_pkg::CS_STATUS_OFS,
                cs_pkg::CS_CONTROL_OFS,
                cs_pkg::CS_INT_STAT_OFS,
                cs_pkg::CS_INT_MASK_OFS: next_cur.pslverr = 1'b0;
                default: next_cur.pslverr = 1'b1;
            endcase
        end
        if (rd_set) begin
            // reads only copy values, nothing is cleared
            case (paddr)
                cs_pkg::CS_STATUS_OFS: begin
                    next_cur.prdata = status_word;  // R14
                end
                cs_pkg::CS_CONTROL_OFS: begin
                    next_cur.prdata = 32'h0000_0000;
                    next_cur.prdata[cs_pkg::CS_CT_CHARGE_EN] = cur.chg_en;
                    next_cur.prdata[cs_pkg::CS_CT_LEARN]     = cur.learn;
                end
                cs_pkg::CS_INT_STAT_OFS: begin
                    next_cur.prdata = {27'h0, cur.int_stat};
                end
                cs_pkg::CS_INT_MASK_OFS: begin
                    next_cur.prdata = {27'h0, cur.int_mask};
                end
                default: begin
                    next_cur.prdata = 32'h0000_0000;
                end
            endcase
        end
        if (wr_acc && paddr == cs_pkg::CS_CONTROL_OFS) begin
            next_cur.chg_en = pwdata[cs_pkg::CS_CT_CHARGE_EN];
            next_cur.learn  = pwdata[cs_pkg::CS_CT_LEARN];  // R13
        end
        if (wr_acc && paddr == cs_pkg::CS_INT_MASK_OFS) begin
            next_cur.int_mask = pwdata[4:0];
        end
        // new event wins over a clear in the same cycle
        next_cur.int_stat = (cur.int_stat & ~w1c) | ev_rise;

        // learn switchover: held until learn is dropped or adapter lost
        if (!next_cur.learn || !ac_present) begin
            next_cur.learn_sw = 1'b0;
        end else if (next_cur.learn && depleted) begin
            next_cur.learn_sw = 1'b1;  // R3
        end

        // overcurrent latch: cleared by software through its event bit
        if (overcur) begin
            next_cur.oc_trip = 1'b1;  // R4
        end else if (w1c[cs_pkg::CS_EV_OVERCUR]) begin
            next_cur.oc_trip = 1'b0;
        end

        // adapter path: overcurrent overrides everything, no delay
        next_cur.gate = ac_want && !overcur && !cur.oc_trip;  // R1 R2 R4

        // thermal shutdown with hysteresis
        if (die_temp_c > cs_pkg::CS_TSHUT_ON_C) begin
            next_cur.tshut = 1'b1;  // R6
        end else if (die_temp_c < cs_pkg::CS_TSHUT_OFF_C) begin
            next_cur.tshut = 1'b0;  // R8
        end

        // charger runs when enabled, adapter present, not shut down and neither thermistor flag set; restart needs no host action
        next_cur.chg_on = cur.chg_en && !next_cur.tshut && ac_present &&
                          !therm_cold && !therm_hot;  // R6 R8

        // reference only when the adapter can supply it
        next_cur.ref_en = ac_present;  // R12
        next_cur.alarm  = next_cur.tshut;  // R6
        next_cur.irq    = |(next_cur.int_stat & cur.int_mask);
    end

    // single state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur          <= '0;
            cur.chg_en   <= cs_pkg::CS_CHARGE_EN_RST;
            cur.learn    <= cs_pkg::CS_LEARN_RST;
            cur.int_mask <= cs_pkg::CS_INT_MASK_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from flops
    assign prdata                    = cur.prdata;
    assign pready                    = cur.pready;
    assign pslverr                   = cur.pslverr;
    assign adapter_switch_gate_drive = cur.gate;
    assign charger_enable            = cur.chg_on;
    assign five_volt_reference       = cur.ref_en;
    assign alarm                     = cur.alarm;
    assign irq                       = cur.irq;

    // overcurrent drops the gate at the next edge
    property p_oc_cut;
        @(posedge clk) disable iff (!rst_b)
        overcur |=> !adapter_switch_gate_drive;
    endproperty
    a_oc_cut: assert property (p_oc_cut)  // R4
        else $error("gate still on after overcurrent");

    // gate only with adapter present and learn clear or switched
    property p_gate_cause;
        @(posedge clk) disable iff (!rst_b)
        $rose(adapter_switch_gate_drive) |->
            $past(ac_present) && (!$past(cur.learn) || $past(cur.learn_sw));
    endproperty
    a_gate_cause: assert property (p_gate_cause)  // R2
        else $error("gate rose without adapter or with learn set");

    // depleted battery in learn cycle moves supply to adapter
    property p_learn_sw;
        @(posedge clk) disable iff (!rst_b)
        (cur.learn && ac_present && depleted && !overcur && !cur.oc_trip)
            ##1 (cur.learn && ac_present && !overcur && !cur.oc_trip)
            |=> adapter_switch_gate_drive;
    endproperty
    a_learn_sw: assert property (p_learn_sw)  // R3
        else $error("no switchover on depleted battery");

    // hot die forces shutdown, charger off and alarm
    property p_hot_die;
        @(posedge clk) disable iff (!rst_b)
        die_temp_c > cs_pkg::CS_TSHUT_ON_C |=> alarm && !charger_enable;
    endproperty
    a_hot_die: assert property (p_hot_die)  // R6
        else $error("no shutdown above trip temperature");

    // shutdown holds inside the hysteresis band
    property p_hyst;
        @(posedge clk) disable iff (!rst_b)
        cur.tshut && die_temp_c >= cs_pkg::CS_TSHUT_OFF_C |=> cur.tshut;
    endproperty
    a_hyst: assert property (p_hyst)  // R8
        else $error("shutdown released above release temperature");

    // restart without host action once cool
    property p_restart;
        @(posedge clk) disable iff (!rst_b)
        cur.tshut && die_temp_c < cs_pkg::CS_TSHUT_OFF_C |=> !alarm;
    endproperty
    a_restart: assert property (p_restart)  // R8
        else $error("shutdown not released when cool");

    // bus answers during shutdown
    property p_bus_alive;
        @(posedge clk) disable iff (!rst_b)
        psel && !penable && !pready |=> pready;
    endproperty
    a_bus_alive: assert property (p_bus_alive)  // R7
        else $error("no apb answer");

    // reference follows adapter detection
    property p_ref;
        @(posedge clk) disable iff (!rst_b)
        ac_present |=> five_volt_reference;
    endproperty
    a_ref: assert property (p_ref)  // R12
        else $error("reference off with adapter present");

    // status read returns live flags and changes nothing
    property p_status_rd;
        @(posedge clk) disable iff (!rst_b)
        rd_set && paddr == cs_pkg::CS_STATUS_OFS |=>
            prdata[cs_pkg::CS_ST_ADAPTER_PATH] == $past(cur.gate) &&
            prdata[cs_pkg::CS_ST_HOT] == $past(therm_hot) &&
            cur.int_stat == ($past(cur.int_stat) | $past(ev_rise));
    endproperty
    a_status_rd: assert property (p_status_rd)  // R1 R10 R14
        else $error("status read wrong or had side effect");

    // while charging, only the operating hot level keeps it running
    property p_hot_sel;
        @(posedge clk) disable iff (!rst_b)
        charger_enable && $past(charger_enable) |->
            !$past(pin[cs_pkg::CS_IN_HOT_OP]);
    endproperty
    a_hot_sel: assert property (p_hot_sel)  // R11
        else $error("charging went on above the operating hot level");

    // charging starts only below the start hot level
    property p_hot_start;
        @(posedge clk) disable iff (!rst_b)
        $rose(charger_enable) |-> !$past(pin[cs_pkg::CS_IN_HOT_ST]);
    endproperty
    a_hot_start: assert property (p_hot_start)  // R11
        else $error("charging started above the start hot level");

    // shutdown flag and a running charger never coexist
    property p_off_flag;
        @(posedge clk) disable iff (!rst_b)
        alarm |-> !charger_enable;
    endproperty
    a_off_flag: assert property (p_off_flag)  // R5 R6
        else $error("charger running during thermal shutdown");

    // the trip latch keeps the adapter path off until cleared
    property p_oc_hold;
        @(posedge clk) disable iff (!rst_b)
        cur.oc_trip |=> !adapter_switch_gate_drive;
    endproperty
    a_oc_hold: assert property (p_oc_hold)  // R4
        else $error("gate on while overcurrent latched");

endmodule

/* verilog/cs_pkg.sv */
package cs_pkg;

    // apb register byte offsets
    localparam logic [7:0] CS_STATUS_OFS   = 8'h00;  // live status word
    localparam logic [7:0] CS_CONTROL_OFS  = 8'h04;  // host control
    localparam logic [7:0] CS_INT_STAT_OFS = 8'h08;  // sticky events, w1c
    localparam logic [7:0] CS_INT_MASK_OFS = 8'h0c;  // event enables

    // status word bit positions
    localparam int CS_ST_ADAPTER_PATH = 7;   // adapter feeds system
    localparam int CS_ST_THERMAL_OFF  = 8;   // die over-temperature
    localparam int CS_ST_COLD         = 9;   // thermistor too cold
    localparam int CS_ST_HOT          = 10;  // thermistor too hot

    // control word bit positions
    localparam int CS_CT_CHARGE_EN = 0;  // host charge enable
    localparam int CS_CT_LEARN     = 4;  // learn cycle select

    // control reset values
    localparam logic CS_CHARGE_EN_RST = 1'b0;
    localparam logic CS_LEARN_RST     = 1'b0;

    // event bit positions in int status and int mask
    localparam int CS_EV_THERMAL  = 0;  // thermal shutdown entered
    localparam int CS_EV_OVERCUR  = 1;  // adapter overcurrent trip
    localparam int CS_EV_LEARN_SW = 2;  // learn-cycle switchover
    localparam int CS_EV_COLD     = 3;  // thermistor went cold
    localparam int CS_EV_HOT      = 4;  // thermistor went hot
    localparam int CS_EV_N        = 5;  // number of events
    localparam logic [4:0] CS_INT_MASK_RST = 5'h00;

    // die temperature thresholds, degrees celsius
    localparam logic [7:0] CS_TSHUT_ON_C  = 8'h91;  // 145 C trip
    localparam logic [7:0] CS_TSHUT_OFF_C = 8'h82;  // 130 C release

    // index of each synchronised pin input
    localparam int CS_IN_ADAPTER  = 0;  // adapter detect comparator
    localparam int CS_IN_OVERCUR  = 1;  // adapter overcurrent comparator
    localparam int CS_IN_DEPLETED = 2;  // battery below depleted level
    localparam int CS_IN_COLD     = 3;  // thermistor above cold level
    localparam int CS_IN_HOT_ST   = 4;  // below hot level, start
    localparam int CS_IN_HOT_OP   = 5;  // below hot level, operating
    localparam int CS_IN_N        = 6;

endpackage

/* verilog/cs_sync.sv */
`timescale 1ns/100ps
// three-stage synchroniser; a change is accepted once stages two and
// three agree, so a single-cycle metastable sample never reaches q
module cs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // asynchronous levels in, filtered levels out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;   // first stage, read only by s2
        logic [W-1:0] s2;   // second stage
        logic [W-1:0] s3;   // third stage
        logic [W-1:0] q;    // accepted level
    } cs_sync_state_t;

    cs_sync_state_t cur;       // registered state
    cs_sync_state_t next_cur;  // next state
    logic [W-1:0]   acc;       // per-bit next accepted level

    // shift chain; q takes the per-bit acceptance
    always_comb begin
        next_cur    = cur;
        next_cur.s1 = d;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
        next_cur.q  = acc;
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // accept only when the two settled stages agree
            assign acc[i] = (cur.s2[i] == cur.s3[i]) ? cur.s3[i] : cur.q[i];
        end
    endgenerate

    // one register for all stages and the accepted level, so the
    // state has a single driving process
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign q = cur.q;

endmodule

/* test/cs_host.sv */
`timescale 1ns/100ps
// host model: apb master standing in for the power-management micro
module cs_host (
    // clock
    input  wire logic        clk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // idle bus from time zero so the slave never sees an unknown select
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // one transfer; a dead cycle first so no signal is driven twice
    // in one time step when transfers follow each other
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // hold everything until pready is seen high at an edge
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released data shows a fresh pattern, not the old word
        pwdata  <= ~wdata;
    endtask
endmodule

/* test/tb_cs_selector.sv */
`timescale 1ns/100ps
// bench: drives pins, runs a reference model, compares every result
module tb_cs_selector;
    logic        clk, rst_b;                  // clock, active-low reset
    logic        psel, penable, pwrite;       // apb from host model
    logic [7:0]  paddr;                       // apb address
    logic [31:0] pwdata, prdata;              // apb data
    logic        pready, pslverr;             // apb answer
    logic        adp, oc, dep, cold, hs, ho;  // comparator pins
    logic [7:0]  temp;                        // die temperature
    logic        gate, chg_o, vref, alarm, irq;
    int          failures, tests_run, cycles;
    int          learn, chg_en, mask, stat;   // model registers
    int          ocl, sw, shut, coldf, hotf, chg, g;  // model state
    logic [31:0] seed, rd;                    // xorshift state, read word
    logic        err;                         // last pslverr
    logic [7:0]  tt [5] = '{8'h91, 8'h92, 8'h8c, 8'h82, 8'h81};

    // 200 mhz clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    cs_selector cs_selector_inst (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adapter_detect_input(adp), .adapter_overcurrent_event(oc),
        .battery_depleted_threshold(dep), .therm_above_cold(cold),
        .therm_below_hot_start(hs), .therm_below_hot_oper(ho),
        .die_temp_c(temp), .adapter_switch_gate_drive(gate),
        .charger_enable(chg_o), .five_volt_reference(vref),
        .alarm(alarm), .irq(irq));

    cs_host cs_host_inst (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // verdict and end of run, reached from the main flow or the timeout
    task finish_test;
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard, far above the expected run of about 1300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // register read compared with the model, response code too
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic e);
        cs_host_inst.xfer(1'b0, a, 32'h0, rd, err);
        cmp_word(rd, exp);
        cmp_bit(err, e);
    endtask

    // register write, mirrored into the model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cs_host_inst.xfer(1'b1, a, d, rd, err);
        case (a)
            cs_pkg::CS_CONTROL_OFS: begin
                learn  = d[cs_pkg::CS_CT_LEARN];
                chg_en = d[cs_pkg::CS_CT_CHARGE_EN];
            end
            cs_pkg::CS_INT_STAT_OFS: begin
                stat &= ~d;
                // the trip latch only lets go once the fault is gone
                if (d[cs_pkg::CS_EV_OVERCUR] && !oc) ocl = 0;
            end
            cs_pkg::CS_INT_MASK_OFS: mask = d[4:0];
            default: ;
        endcase
    endtask

    // model: settle all flags from the present pins and registers
    task automatic step;
        int ps, ph, pc, base;
        ps = sw;
        ph = hotf;
        pc = coldf;
        if (oc) begin
            if (ocl == 0) stat |= 1 << cs_pkg::CS_EV_OVERCUR;
            ocl = 1;
        end
        if (!learn || !adp) sw = 0;
        else if (dep) sw = 1;
        if (sw && !ps) stat |= 1 << cs_pkg::CS_EV_LEARN_SW;
        g = adp && !ocl && (!learn || sw);
        if (temp > cs_pkg::CS_TSHUT_ON_C) begin
            if (!shut) stat |= 1 << cs_pkg::CS_EV_THERMAL;
            shut = 1;
        end else if (temp < cs_pkg::CS_TSHUT_OFF_C) begin
            shut = 0;
        end
        coldf = cold;
        if (coldf && !pc) stat |= 1 << cs_pkg::CS_EV_COLD;
        base = chg_en && !shut && adp && !coldf;
        // hot level follows the charger state; two passes settle it
        hotf = chg ? ho : hs;
        chg  = base && !hotf;
        hotf = chg ? ho : hs;
        chg  = base && !hotf;
        if (hotf && !ph) stat |= 1 << cs_pkg::CS_EV_HOT;
    endtask

    // let the synchronisers settle, then compare every output
    task automatic check_all;
        logic [31:0] sword;
        repeat (8) @(posedge clk);
        step;
        sword = (32'(g) << cs_pkg::CS_ST_ADAPTER_PATH)
              | (32'(shut) << cs_pkg::CS_ST_THERMAL_OFF)
              | (32'(coldf) << cs_pkg::CS_ST_COLD)
              | (32'(hotf) << cs_pkg::CS_ST_HOT);
        cmp_bit(gate, g[0]);
        cmp_bit(chg_o, chg[0]);
        cmp_bit(vref, adp);
        cmp_bit(alarm, shut[0]);
        cmp_bit(irq, (stat & mask) != 0);
        rd_chk(cs_pkg::CS_STATUS_OFS, sword, 1'b0);
        rd_chk(cs_pkg::CS_INT_STAT_OFS, 32'(stat), 1'b0);
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        {adp, oc, dep, cold, hs, ho} = 6'h00;
        temp = 8'h19;
        seed = 32'h47a9;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        check_all;
        rd_chk(cs_pkg::CS_CONTROL_OFS, 32'h0, 1'b0);
        rd_chk(cs_pkg::CS_INT_MASK_OFS, 32'h0, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        wr(8'h10, 32'hffffffff);
        cmp_bit(err, 1'b1);
        wr(cs_pkg::CS_INT_MASK_OFS, 32'h1f);
        wr(cs_pkg::CS_CONTROL_OFS, 32'h1);
        @(posedge clk);
        adp <= 1'b1;
        check_all;
        // trip and release edges of the die temperature
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            temp <= tt[i];
            check_all;
        end
        wr(cs_pkg::CS_CONTROL_OFS, 32'h11);
        check_all;
        @(posedge clk);
        dep <= 1'b1;
        check_all;
        @(posedge clk);
        dep <= 1'b0;
        check_all;
        wr(cs_pkg::CS_CONTROL_OFS, 32'h1);
        check_all;
        @(posedge clk);
        oc <= 1'b1;
        check_all;
        @(posedge clk);
        oc <= 1'b0;
        check_all;
        wr(cs_pkg::CS_INT_STAT_OFS, 32'h2);
        check_all;
        @(posedge clk);
        cold <= 1'b1;
        check_all;
        @(posedge clk);
        cold <= 1'b0;
        check_all;
        @(posedge clk);
        hs <= 1'b1;
        check_all;
        wr(cs_pkg::CS_CONTROL_OFS, 32'h0);
        check_all;
        wr(cs_pkg::CS_CONTROL_OFS, 32'h1);
        check_all;
        @(posedge clk);
        hs <= 1'b0;
        check_all;
        wr(cs_pkg::CS_INT_STAT_OFS, 32'h1f);
        check_all;
        // random single-pin, temperature or control-write steps; operating hot never without start hot
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            @(posedge clk);
            case (seed[2:0])
                3'h0: adp <= ~adp;
                3'h1: dep <= ~dep;
                3'h2: cold <= ~cold;
                3'h3: if (!ho) hs <= ~hs;
                3'h4: if (hs) ho <= ~ho;
                3'h5, 3'h6: temp <= 8'h78 + 8'(seed[15:8] % 8'h28);
                default: wr(cs_pkg::CS_CONTROL_OFS,
                            {27'h0, seed[8], 3'h0, 1'b1});
            endcase
            check_all;
        end
        finish_test;
    end
endmodule
